// File: hw/bcd_top.sv
// Broken conductor detector top: APB register file, decision logic,
// start and trip outputs and event interrupt.
// Assumes magnitudes come from an upstream sequence calculator and
// that all inputs are synchronous to mclk_in.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps

module bcd_top
  import bcd_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS             // Cycles per ms tick
) (
  input  wire logic               mclk_in,      // System clock
  input  wire logic               rst_in,       // Async reset, high
  input  wire logic               ce_in,        // Clock enable
  // APB slave
  input  wire logic               psel_in,      // Select
  input  wire logic               penable_in,   // Access phase
  input  wire logic               pwrite_in,    // Write direction
  input  wire logic [ADDR_W-1:0]  paddr_in,     // Byte address
  input  wire logic [31:0]        pwdata_in,    // Write data
  input  wire logic [3:0]         pstrb_in,     // Byte strobes
  output logic [31:0]             prdata_out,   // Read data
  output logic                    pready_out,   // Transfer done
  output logic                    pslverr_out,  // Unmapped access
  // Measurement side
  input  wire logic               mag_valid_in, // Magnitudes strobe
  input  wire logic [MAG_W-1:0]   positive_seq_magnitude_in,
  input  wire logic [MAG_W-1:0]   negative_seq_magnitude_in,
  input  wire logic               block_in,     // External blocking
  // Protection outputs
  output logic                    start_out,    // General start
  output logic                    trip_out,     // General trip
  output logic                    irq_out       // Event interrupt
);

  // ==========================================================
  // Functions
  // ==========================================================
  // Address match used by both read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Known register address
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFS_CTRL) || hit(a, OFS_RATIO) ||
             hit(a, OFS_DELAY) || hit(a, OFS_RATED) ||
             hit(a, OFS_STATUS) || hit(a, OFS_IRQ_ST) ||
             hit(a, OFS_IRQ_CL) || hit(a, OFS_IRQ_EN);
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  logic               oper_q;        // Operation On
  logic               sonly_q;       // Start signal only
  logic [RATIO_W-1:0] ratio_q;       // Start ratio setting
  logic [DLY_W-1:0]   delay_q;       // Trip delay setting
  logic [MAG_W-1:0]   rated_q;       // Rated current counts
  logic [EV_W-1:0]    irq_st_q;      // Sticky events
  logic [EV_W-1:0]    irq_en_q;      // Event enables
  logic [31:0]        prdata_q;      // Registered read data
  logic               acc_rdy_q;     // Setup phase captured
  logic               err_q;         // Setup address unmapped
  logic               start_q;       // Start output register
  logic               trip_q;        // Trip output register
  logic               ratio_flag;    // Ratio exceeded
  logic               band_flag;     // Positive sequence in band
  logic               cond;          // Start condition
  logic               timer_done;    // Delay elapsed
  logic               wr_en;         // Completing write
  logic               setup;         // Setup phase cycle
  logic [EV_W-1:0]    ev_set;        // Events this cycle
  logic [EV_W-1:0]    ev_clr;        // Software clear this cycle
  logic [31:0]        rd_mux;        // Read data before register
  logic [15:0]        wdata16;       // Low half of write data
  logic [RATIO_W-1:0] wr_ratio;      // Clamped ratio write
  logic [DLY_W-1:0]   wr_delay;      // Clamped delay write

  // ==========================================================
  // APB handshake
  // ==========================================================
  // Setup cycle of a transfer
  assign setup  = psel_in && !penable_in;
  // Write takes effect on the completing edge only
  assign wr_en  = psel_in && penable_in && pwrite_in && pready_out;

  // One wait-free access phase once setup has been seen
  assign pready_out  = acc_rdy_q && ce_in;
  assign pslverr_out = acc_rdy_q && err_q;
  assign prdata_out  = prdata_q;

  // Setup capture and access completion tracking
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_rdy_q <= 1'b0;
      err_q     <= 1'b0;
    end else if (ce_in) begin
      if (setup) begin
        acc_rdy_q <= 1'b1;
        err_q     <= !mapped(paddr_in);
      end else if (acc_rdy_q && psel_in && penable_in) begin
        // Transfer completes this edge
        acc_rdy_q <= 1'b0;
        err_q     <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Write data clamping
  // ==========================================================
  always_comb begin
    wdata16 = pwdata_in[15:0];
    // Keep ratio within 10..90 percent
    if (wdata16 < 16'(MIN_RATIO)) begin
      wr_ratio = MIN_RATIO;
    end else if (wdata16 > 16'(MAX_RATIO)) begin
      wr_ratio = MAX_RATIO;
    end else begin
      wr_ratio = wdata16[RATIO_W-1:0];
    end
    // Keep delay within 100..60000 ms
    if (wdata16 < MIN_DELAY) begin
      wr_delay = MIN_DELAY;
    end else if (wdata16 > MAX_DELAY) begin
      wr_delay = MAX_DELAY;
    end else begin
      wr_delay = wdata16;
    end
  end

  // ==========================================================
  // Setting registers
  // ==========================================================
  // Control bits: operation and start only
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      oper_q  <= RST_OPER;
      sonly_q <= RST_SONLY;
    end else if (ce_in && wr_en && hit(paddr_in, OFS_CTRL) && pstrb_in[0]) begin
      oper_q  <= pwdata_in[CTRL_OPER_BIT];
      sonly_q <= pwdata_in[CTRL_SONLY_BIT];
    end
  end

  // Start ratio setting
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ratio_q <= RST_RATIO;
    end else if (ce_in && wr_en && hit(paddr_in, OFS_RATIO) && pstrb_in[0]) begin
      ratio_q <= wr_ratio;
    end
  end

  // Trip delay setting, both low bytes needed
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      delay_q <= RST_DELAY;
    end else if (ce_in && wr_en && hit(paddr_in, OFS_DELAY) && (&pstrb_in[1:0])) begin
      delay_q <= wr_delay;
    end
  end

  // Rated current scaling
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rated_q <= RST_RATED;
    end else if (ce_in && wr_en && hit(paddr_in, OFS_RATED) && (&pstrb_in[1:0])) begin
      rated_q <= wdata16;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      hit(paddr_in, OFS_CTRL): begin
        rd_mux[CTRL_OPER_BIT]  = oper_q;
        rd_mux[CTRL_SONLY_BIT] = sonly_q;
      end
      hit(paddr_in, OFS_RATIO): begin
        rd_mux[RATIO_W-1:0] = ratio_q;
      end
      hit(paddr_in, OFS_DELAY): begin
        rd_mux[DLY_W-1:0] = delay_q;
      end
      hit(paddr_in, OFS_RATED): begin
        rd_mux[MAG_W-1:0] = rated_q;
      end
      hit(paddr_in, OFS_STATUS): begin
        // Live block state
        rd_mux[ST_START_BIT] = start_q;
        rd_mux[ST_TRIP_BIT]  = trip_q;
        rd_mux[ST_RATIO_BIT] = ratio_flag;
        rd_mux[ST_BAND_BIT]  = band_flag;
        rd_mux[ST_BLOCK_BIT] = block_in;
      end
      hit(paddr_in, OFS_IRQ_ST): begin
        rd_mux[EV_W-1:0] = irq_st_q;
      end
      hit(paddr_in, OFS_IRQ_EN): begin
        rd_mux[EV_W-1:0] = irq_en_q;
      end
      default: begin
        // Clear register and unmapped read as zero
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in setup, stable through access
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce_in && setup) begin
      prdata_q <= pwrite_in ? 32'h0000_0000 : rd_mux;
    end
  end

  // ==========================================================
  // Analogue decision stage
  // ==========================================================
  // Magnitudes arrive ready-made from upstream
  bcd_seq_compare u_cmp (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .valid_in   (mag_valid_in),
    .pos_mag_in (positive_seq_magnitude_in),
    .neg_mag_in (negative_seq_magnitude_in),
    .ratio_in   (ratio_q),
    .rated_in   (rated_q),
    .ratio_out  (ratio_flag),
    .band_out   (band_flag)
  );

  // ==========================================================
  // Decision logic
  // ==========================================================
  // Start condition: enabled, unblocked, ratio high, I1 in band
  assign cond = oper_q &&
                !block_in &&
                ratio_flag &&
                band_flag;

  // Delay timer restarts whenever the condition drops
  bcd_delay_timer #(
    .CYC_MS (CYC_MS)
  ) u_tmr (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .run_in   (cond),
    .delay_in (delay_q),
    .done_out (timer_done)
  );

  // Start follows the condition directly
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      start_q <= 1'b0;
    end else if (ce_in) begin
      start_q <= cond;
    end
  end

  // Trip once delay elapses, unless start only
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trip_q <= 1'b0;
    end else if (ce_in) begin
      trip_q <= timer_done && !sonly_q;
    end
  end

  assign start_out = start_q;
  assign trip_out  = trip_q;

  // ==========================================================
  // Event interrupt
  // ==========================================================
  // Start rise, trip rise and start fall as events
  always_comb begin
    ev_set               = '0;
    ev_set[EV_START_BIT] = cond && !start_q;
    ev_set[EV_TRIP_BIT]  = timer_done && !sonly_q && !trip_q;
    ev_set[EV_DROP_BIT]  = !cond && start_q;
    ev_clr = (wr_en && hit(paddr_in, OFS_IRQ_CL) && pstrb_in[0]) ?
             pwdata_in[EV_W-1:0] : '0;
  end

  // Sticky bits, set wins over clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_st_q <= RST_IRQ;
    end else if (ce_in) begin
      irq_st_q <= (irq_st_q & ~ev_clr) | ev_set;
    end
  end

  // Enable register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en_q <= RST_IRQ;
    end else if (ce_in && wr_en && hit(paddr_in, OFS_IRQ_EN) && pstrb_in[0]) begin
      irq_en_q <= pwdata_in[EV_W-1:0];
    end
  end

  // Level interrupt while an enabled event is pending
  assign irq_out = |(irq_st_q & irq_en_q);

endmodule

// File: hw/bcd_pkg.sv
// Package for the broken conductor detector: register map, field
// positions, reset values, setting limits and timing counts.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.

package bcd_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_PS = 5000;      // 200 MHz clock period
  localparam int TICK_NS       = 1000000;   // Delay resolution, 1 ms
  localparam int CYC_PER_MS    = (TICK_NS * 1000) / CLK_PERIOD_PS;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int MAG_W   = 16;              // Sequence magnitude width
  localparam int RATIO_W = 7;               // Ratio setting width
  localparam int DLY_W   = 16;              // Delay setting width
  localparam int ADDR_W  = 8;               // APB address width

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00; // Operation, start only
  localparam logic [ADDR_W-1:0] OFS_RATIO  = 8'h04; // Start ratio percent
  localparam logic [ADDR_W-1:0] OFS_DELAY  = 8'h08; // Trip delay in ms
  localparam logic [ADDR_W-1:0] OFS_RATED  = 8'h0C; // Rated current counts
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10; // Live state, read only
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 8'h14; // Sticky events, read only
  localparam logic [ADDR_W-1:0] OFS_IRQ_CL = 8'h18; // Event clear, write only
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h1C; // Event enable

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_OPER_BIT  = 0;        // Operation On
  localparam int CTRL_SONLY_BIT = 1;        // Start signal only
  localparam int ST_START_BIT   = 0;        // Start output
  localparam int ST_TRIP_BIT    = 1;        // Trip output
  localparam int ST_RATIO_BIT   = 2;        // Ratio exceeded flag
  localparam int ST_BAND_BIT    = 3;        // Positive sequence in band
  localparam int ST_BLOCK_BIT   = 4;        // Blocking input
  localparam int EV_START_BIT   = 0;        // Start rising event
  localparam int EV_TRIP_BIT    = 1;        // Trip rising event
  localparam int EV_DROP_BIT    = 2;        // Start falling event
  localparam int EV_W           = 3;        // Event register width

  // ==========================================================
  // Reset values and setting limits
  // ==========================================================
  localparam logic                RST_OPER  = 1'b0;       // Off
  localparam logic                RST_SONLY = 1'b0;       // False
  localparam logic [RATIO_W-1:0]  RST_RATIO = 7'd50;
  localparam logic [RATIO_W-1:0]  MIN_RATIO = 7'd10;
  localparam logic [RATIO_W-1:0]  MAX_RATIO = 7'd90;
  localparam logic [DLY_W-1:0]    RST_DELAY = 16'd1000;
  localparam logic [DLY_W-1:0]    MIN_DELAY = 16'd100;
  localparam logic [DLY_W-1:0]    MAX_DELAY = 16'd60000;
  localparam logic [MAG_W-1:0]    RST_RATED = 16'h1000;   // 1.0 In
  localparam logic [EV_W-1:0]     RST_IRQ   = 3'h0;

  // Band limits as fractions of rated current, in 1/10000 units
  localparam logic [13:0] BAND_LO_BP = 14'd667;     // 6.67 %
  localparam logic [13:0] BAND_HI_BP = 14'd10000;   // 100 %
  localparam logic [13:0] BP_SCALE   = 14'd10000;
  localparam logic [6:0]  PCT_SCALE  = 7'd100;

endpackage

// File: hw/bcd_seq_compare.sv
// Analogue decision stage: turns sequence magnitudes into ratio and
// band flags. Assumes magnitudes are valid on the strobe cycle.
`timescale 1ns/1ps

module bcd_seq_compare
  import bcd_pkg::*;
(
  input  wire logic               mclk_in,      // System clock
  input  wire logic               rst_in,       // Async reset, high
  input  wire logic               ce_in,        // Clock enable
  input  wire logic               valid_in,     // New magnitudes
  input  wire logic [MAG_W-1:0]   pos_mag_in,   // Positive sequence
  input  wire logic [MAG_W-1:0]   neg_mag_in,   // Negative sequence
  input  wire logic [RATIO_W-1:0] ratio_in,     // Start ratio percent
  input  wire logic [MAG_W-1:0]   rated_in,     // Rated current counts
  output logic                    ratio_out,    // Ratio exceeded flag
  output logic                    band_out      // In-band flag
);

  // ==========================================================
  // Scaled products
  // ==========================================================
  logic [31:0] neg_pct;    // I2 * 100
  logic [31:0] pos_pct;    // I1 * setting
  logic [31:0] pos_bp;     // I1 * 10000
  logic [31:0] lo_bp;      // Rated * 667
  logic [31:0] hi_bp;      // Rated * 10000

  always_comb begin
    neg_pct = 32'(neg_mag_in) * 32'(PCT_SCALE);
    pos_pct = 32'(pos_mag_in) * 32'(ratio_in);
    pos_bp  = 32'(pos_mag_in) * 32'(BP_SCALE);
    lo_bp   = 32'(rated_in) * 32'(BAND_LO_BP);
    hi_bp   = 32'(rated_in) * 32'(BAND_HI_BP);
  end

  // ==========================================================
  // Flag registers, updated per sample
  // ==========================================================
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ratio_out <= 1'b0;
      band_out  <= 1'b0;
    end else if (ce_in && valid_in) begin
      // Ratio as percent compared against setting
      ratio_out <= (neg_pct > pos_pct);
      // Positive sequence between 6.67 % and 100 % of rated
      band_out  <= (pos_bp > lo_bp) && (pos_bp < hi_bp);
    end
  end

endmodule

// File: hw/bcd_delay_timer.sv
// Trip delay timer counting whole milliseconds while its run input
// is high; restarts from zero whenever run drops.
`timescale 1ns/1ps

module bcd_delay_timer
  import bcd_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS             // Clock cycles per ms
) (
  input  wire logic             mclk_in,        // System clock
  input  wire logic             rst_in,         // Async reset, high
  input  wire logic             ce_in,          // Clock enable
  input  wire logic             run_in,         // Condition present
  input  wire logic [DLY_W-1:0] delay_in,       // Delay in ms
  output logic                  done_out        // Delay elapsed
);

  // ==========================================================
  // Prescaler and millisecond counter
  // ==========================================================
  logic [17:0]      pre_q;     // Cycles within current ms
  logic [DLY_W-1:0] ms_q;      // Elapsed whole ms

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= '0;
      ms_q  <= '0;
    end else if (ce_in) begin
      if (!run_in) begin
        // Drop restarts the delay
        pre_q <= '0;
        ms_q  <= '0;
      end else if (ms_q < delay_in) begin
        if (pre_q == 18'(CYC_MS - 1)) begin
          pre_q <= '0;
          ms_q  <= ms_q + 16'd1;
        end else begin
          pre_q <= pre_q + 18'd1;
        end
      end
    end
  end

  // Expiry while the condition still holds
  assign done_out = run_in && (ms_q >= delay_in);

endmodule

// File: dv/bcd_monitor.sv
// Checker for start, trip and blocking.
// Assumes a bind to bcd_top ports.
`timescale 1ns/1ps

module bcd_monitor
  import bcd_pkg::*;
#(
  parameter int CYC_MS = 4                      // Cycles per ms tick
) (
  input  wire logic             mclk_in,        // System clock
  input  wire logic             rst_in,         // Async reset, high
  input  wire logic             ce_in,          // Clock enable
  input  wire logic             mag_valid_in,   // Magnitudes strobe
  input  wire logic [MAG_W-1:0] positive_seq_magnitude_in,
  input  wire logic [MAG_W-1:0] negative_seq_magnitude_in,
  input  wire logic             block_in,       // External blocking
  input  wire logic             start_out,      // General start
  input  wire logic             trip_out        // General trip
);
  logic [31:0] run_q;                           // Cycles start stood
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Counts unbroken start cycles
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= '0;
    end else if (!start_out) begin
      run_q <= '0;
    end else if (ce_in) begin
      run_q <= run_q + 32'd1;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_block_kills_start: assert property (
    block_in && ce_in |=> !start_out) else $error("start while blocked");
  a_trip_needs_start: assert property (
    trip_out |-> start_out) else $error("trip without start");
  a_fresh_start_quiet: assert property (
    $rose(start_out) |-> !trip_out [*8]) else $error("early trip");
  a_trip_min_delay: assert property (
    $rose(trip_out) |-> run_q >= 32'(100 * CYC_MS - 2)) else $error("trip too early");
  a_band_low_idle: assert property (
    mag_valid_in && ce_in && positive_seq_magnitude_in == '0 |-> ##2 !start_out)
    else $error("start, no current");
  a_ratio_zero_idle: assert property (
    mag_valid_in && ce_in && negative_seq_magnitude_in == '0 |-> ##2 !start_out)
    else $error("start, zero ratio");
  a_trip_holds: assert property (
    trip_out ##1 start_out |-> trip_out) else $error("trip fell");
  a_freeze_outputs: assert property (
    !ce_in |=> $stable(start_out) && $stable(trip_out)) else $error("moved while frozen");

  // Main scenarios reached
  c_trip: cover property ($rose(trip_out));
  c_drop: cover property ($fell(start_out));
  c_block: cover property (block_in && start_out);
endmodule

// File: dv/bcd_src_model.sv
// Upstream sequence source and user blocking model.
// Assumes the bench calls its tasks after clock edges.
`timescale 1ns/1ps

module bcd_src_model
  import bcd_pkg::*;
(
  input  wire logic             mclk_in,        // System clock
  output logic                  mag_valid_out = 1'b0, // Magnitudes strobe
  output logic [MAG_W-1:0]      pos_mag_out = '0,     // Positive sequence
  output logic [MAG_W-1:0]      neg_mag_out = '0,     // Negative sequence
  output logic                  block_out = 1'b0      // User blocking
);
  // One strobed magnitude pair
  task automatic send(input logic [MAG_W-1:0] p, input logic [MAG_W-1:0] n);
    @(posedge mclk_in);
    mag_valid_out <= 1'b1;
    pos_mag_out   <= p;
    neg_mag_out   <= n;
    @(posedge mclk_in);
    mag_valid_out <= 1'b0;
    pos_mag_out   <= ~p;
    neg_mag_out   <= ~n;
  endtask

  // User block level
  task automatic set_block(input logic b);
    @(posedge mclk_in);
    block_out <= b;
  endtask
endmodule

// File: dv/testbench.sv
// Detector bench: APB master and scenarios.
// Assumes bcd_top with a short ms tick.
`timescale 1ns/1ps

module testbench;
  import bcd_pkg::*;
  localparam int CMS = 4;                       // Short ms tick
  localparam int DCY = 100 * CMS;               // Min delay, cycles
  logic             mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
  logic             psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]       paddr_in = '0;              // APB address
  logic [31:0]      pwdata_in, prdata_out, rdat;
  logic             pready_out, pslverr_out, serr;
  logic             valid, block, start_out, trip_out, irq_out;
  logic [15:0]      pos, neg;                   // Model magnitudes
  int               miscompares = 0, checks_done = 0, n;

  bcd_top #(.CYC_MS(CMS)) u_bcd_top (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(4'hF), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .mag_valid_in(valid), .positive_seq_magnitude_in(pos),
    .negative_seq_magnitude_in(neg), .block_in(block), .start_out(start_out),
    .trip_out(trip_out), .irq_out(irq_out));
  bcd_src_model u_bcd_src_model (.mclk_in(mclk_in), .mag_valid_out(valid),
    .pos_mag_out(pos), .neg_mag_out(neg), .block_out(block));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  always #2.5 mclk_in = ~mclk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge mclk_in);
  endtask

  // One APB transfer, answer taken at completion
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    rdat = prdata_out;
    serr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    chk(k < 50, 1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  // Send a pair, check start
  task automatic cond(input logic [15:0] p, input logic [15:0] q, input logic e);
    u_bcd_src_model.send(p, q);
    wt(4);
    chk(start_out, e);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_settings();
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_RATIO, 32'h0000_0032);
    rd(OFS_DELAY, 32'h0000_03E8);
    rd(OFS_RATED, 32'h0000_1000);
    rd(OFS_IRQ_EN, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    chk(serr, 1);
    wr(OFS_RATIO, 32'h0000_0005);
    rd(OFS_RATIO, 32'h0000_000A);
    wr(OFS_RATIO, 32'h0000_005F);
    rd(OFS_RATIO, 32'h0000_005A);
    wr(OFS_DELAY, 32'h0000_FFFF);
    rd(OFS_DELAY, 32'h0000_EA60);
    wr(OFS_DELAY, 32'h0000_0032);
    rd(OFS_DELAY, 32'h0000_0064);
    cond(16'h0800, 16'h0600, 1'b0);
    wr(OFS_CTRL, 32'h0000_0001);
  endtask

  // Ratio and band edges
  task automatic t_ratio_band();
    cond(16'h0400, 16'h0399, 1'b0);
    cond(16'h0400, 16'h039A, 1'b1);
    wr(OFS_RATIO, 32'h0000_000A);
    cond(16'h0400, 16'h0066, 1'b0);
    cond(16'h0400, 16'h0067, 1'b1);
    wr(OFS_RATIO, 32'h0000_0032);
    cond(16'h0111, 16'h0100, 1'b0);
    cond(16'h0112, 16'h0100, 1'b1);
    cond(16'h1000, 16'h0900, 1'b0);
    cond(16'h0FFF, 16'h0900, 1'b1);
    u_bcd_src_model.set_block(1'b1);
    wt(2);
    chk(start_out, 0);
    u_bcd_src_model.set_block(1'b0);
    wt(3);
    chk(start_out, 1);
    cond(16'h0000, 16'h0800, 1'b0);
  endtask

  // Trip timing, events and restart
  task automatic t_trip();
    wr(OFS_IRQ_CL, 32'h0000_0007);
    wr(OFS_IRQ_EN, 32'h0000_0003);
    cond(16'h0800, 16'h0600, 1'b1);
    n = 0;
    while (trip_out !== 1'b1 && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
    chk(n >= DCY - 4 && n <= DCY + 6, 1);
    chk(irq_out, 1);
    rd(OFS_IRQ_ST, 32'h0000_0003);
    wr(OFS_IRQ_CL, 32'h0000_0003);
    wt(1);
    chk(irq_out, 0);
    cond(16'h0800, 16'h0000, 1'b0);
    chk(trip_out, 0);
    rd(OFS_IRQ_ST, 32'h0000_0004);
    chk(irq_out, 0);
    wr(OFS_IRQ_EN, 32'h0000_0004);
    wt(1);
    chk(irq_out, 1);
    wr(OFS_IRQ_CL, 32'h0000_0007);
    wt(1);
    chk(irq_out, 0);
    cond(16'h0800, 16'h0600, 1'b1);
    wt(DCY / 2);
    cond(16'h0800, 16'h0000, 1'b0);
    cond(16'h0800, 16'h0600, 1'b1);
    wt(DCY / 2 + 20);
    chk(trip_out, 0);
  endtask

  // Start only; frozen enable drops a strobe
  task automatic t_start_only();
    wr(OFS_CTRL, 32'h0000_0003);
    @(posedge mclk_in);
    ce_in <= 1'b0;
    u_bcd_src_model.send(16'h0800, 16'h0000);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    wt(3);
    chk(start_out, 1);
    wt(DCY + 20);
    chk(trip_out, 0);
    chk(start_out, 1);
    wr(OFS_CTRL, 32'h0000_0000);
    wt(3);
    chk(start_out, 0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    pwdata_in = '0;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_settings();
    t_ratio_band();
    t_trip();
    t_start_only();
    print_verdict();
  end

  initial begin
    #100_000;
    miscompares++;
    print_verdict();
  end
endmodule

bind bcd_top bcd_monitor #(.CYC_MS(CYC_MS)) u_bcd_monitor (.mclk_in(mclk_in), .rst_in(rst_in),
  .ce_in(ce_in), .mag_valid_in(mag_valid_in), .positive_seq_magnitude_in(positive_seq_magnitude_in),
  .negative_seq_magnitude_in(negative_seq_magnitude_in), .block_in(block_in),
  .start_out(start_out), .trip_out(trip_out));
